// ===== hdl/cvs_pkg.sv
// package: register offsets, field positions, reset values and carriers for the charge-voltage/status bank
package cvs_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CVS_OFS_CHARGE_VOLTAGE = 8'h15;
  localparam logic [7:0] CVS_OFS_STATE_FLAGS = 8'h20;
  localparam logic [15:0] CVS_RST_CHARGE_VOLTAGE = 16'h0000;
  localparam logic [15:0] CVS_RST_STATE_FLAGS = 16'h0000;
  localparam logic [15:0] CVS_CV_SETPOINT_MASK = 16'h7FF8;
  localparam int CVS_CV_RSVD_TOP_BIT = 15;
  localparam int CVS_CV_SET_LSB = 3;
  localparam int CVS_CV_SET_MSB = 14;
  localparam int CVS_CV_LSB_MV = 8;

  // ****************************************
  // status bit positions
  // ****************************************
  localparam int CVS_ST_INPUT_PRESENT = 15;
  localparam int CVS_ST_OPTIMIZER_DONE = 14;
  localparam int CVS_ST_ASSIST_ACTIVE = 13;
  localparam int CVS_ST_VOLT_REG = 12;
  localparam int CVS_ST_CURR_REG = 11;
  localparam int CVS_ST_FAST_CHARGE = 10;
  localparam int CVS_ST_PRECHARGE = 9;
  localparam int CVS_ST_REVERSE = 8;

  // live conditions reported by the analog/charge core
  typedef struct packed {
    logic input_present;
    logic input_optimizer_done;
    logic input_voltage_regulating;
    logic input_current_regulating;
    logic fast_charge_active;
    logic precharge_active;
    logic reverse_power_active;
  } cvs_cond_type;

  // faults that pull the charger-ok indication and exit assist mode
  typedef struct packed {
    logic input_overcurrent;
    logic thermal_shutdown;
    logic system_overvoltage;
    logic system_undervoltage;
    logic battery_overvoltage;
  } cvs_fault_type;

  // loop and monitor enables driven to the regulation core
  typedef struct packed {
    logic input_voltage_loop_en;
    logic input_current_loop_en;
    logic critical_current_limit_en;
    logic current_limit_pin_en;
    logic adapter_ok_monitor_en;
    logic system_voltage_monitor_en;
  } cvs_loop_type;

  // loops on, both monitors off until the host configuration is sampled
  localparam cvs_loop_type CVS_RST_LOOPS = 6'h3c;

  // register access strobe from the SMBus engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } cvs_acc_type;

endpackage

// ===== hdl/cvs_assist_ctl.sv
// peak-assist mode state and its loop enable side effects
`timescale 1ns/100ps
module cvs_assist_ctl
  import cvs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic ctrl_pin_in,
  input wire logic assist_disable_bit_in,
  input wire logic any_fault_in,
  input wire logic adapter_ok_cfg_in,
  input wire logic system_voltage_cfg_in,
  output logic assist_active_out,
  output logic exit_pulse_out,
  output cvs_loop_type loops_out
);

  typedef enum logic [1:0] {CVS_IDLE, CVS_ACTIVE, CVS_FAULT_HOLD} cvs_assist_state_type;

  cvs_assist_state_type state_r;
  cvs_assist_state_type state_nxt;
  logic exit_r;
  logic exit_nxt;
  cvs_loop_type loops_r;
  cvs_loop_type loops_nxt;
  logic request;

  // ****************************************
  // mode state
  // ****************************************
  // processor-hot state is not an input here, so it cannot block entry
  assign request = ctrl_pin_in & ~assist_disable_bit_in;

  always_comb
  begin
    state_nxt = state_r;
    exit_nxt = 1'b0;
    unique case (state_r)
      CVS_IDLE:
      begin
        if (request && !any_fault_in)
        begin
          state_nxt = CVS_ACTIVE;
        end
      end
      CVS_ACTIVE:
      begin
        if (any_fault_in)
        begin
          state_nxt = CVS_FAULT_HOLD;
          exit_nxt = 1'b1;
        end
        else if (!request)
        begin
          state_nxt = CVS_IDLE;
          exit_nxt = 1'b1;
        end
      end
      CVS_FAULT_HOLD:
      begin
        // re-entry needs a fresh command after the fault forced an exit
        if (!request && !any_fault_in)
        begin
          state_nxt = CVS_IDLE;
        end
      end
      default:
      begin
        state_nxt = CVS_IDLE;
      end
    endcase
  end

  // ****************************************
  // side effects on entry and exit
  // ****************************************
  always_comb
  begin
    loops_nxt = loops_r;
    if (state_nxt == CVS_ACTIVE && state_r != CVS_ACTIVE)
    begin
      loops_nxt.input_voltage_loop_en = 1'b0;
      loops_nxt.input_current_loop_en = 1'b0;
      loops_nxt.critical_current_limit_en = 1'b0;
      loops_nxt.current_limit_pin_en = 1'b0;
      loops_nxt.adapter_ok_monitor_en = 1'b0;
      loops_nxt.system_voltage_monitor_en = 1'b1;
    end
    else if (state_nxt != CVS_ACTIVE && state_r == CVS_ACTIVE)
    begin
      loops_nxt.input_voltage_loop_en = 1'b1;
      loops_nxt.input_current_loop_en = 1'b1;
      loops_nxt.critical_current_limit_en = 1'b1;
      loops_nxt.current_limit_pin_en = 1'b1;
      loops_nxt.adapter_ok_monitor_en = adapter_ok_cfg_in;
      loops_nxt.system_voltage_monitor_en = system_voltage_cfg_in;
    end
    else if (state_r != CVS_ACTIVE)
    begin
      loops_nxt.adapter_ok_monitor_en = adapter_ok_cfg_in;
      loops_nxt.system_voltage_monitor_en = system_voltage_cfg_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= CVS_IDLE;
      exit_r <= 1'b0;
      loops_r <= CVS_RST_LOOPS;
    end
    else if (clk_en_in)
    begin
      state_r <= state_nxt;
      exit_r <= exit_nxt;
      loops_r <= loops_nxt;
    end
  end

  assign assist_active_out = (state_r == CVS_ACTIVE);
  assign exit_pulse_out = exit_r & clk_en_in;
  assign loops_out = loops_r;

endmodule

// ===== hdl/cvs_exit_flag.sv
// sticky assist-exit flag with processor-hot alert drive
`timescale 1ns/100ps
module cvs_exit_flag
  import cvs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic set_in,
  input wire logic clear_in,
  output logic flag_out,
  output logic processor_hot_alert_n_out
);

  logic flag_r;
  logic flag_nxt;

  // set beats a same-cycle host clear so no exit is lost
  always_comb
  begin
    flag_nxt = flag_r;
    if (clear_in)
    begin
      flag_nxt = 1'b0;
    end
    if (set_in)
    begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      flag_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      flag_r <= flag_nxt;
    end
  end

  assign flag_out = flag_r;
  assign processor_hot_alert_n_out = ~flag_r;

endmodule

// ===== hdl/cvs_regs.sv
// charge-voltage setpoint and charger state flags register bank
`timescale 1ns/100ps
// Functional notes
// - bit 15 set makes write invalid
// - bits 14..3 weighted setpoint, 8 mV lsb
// - bits 2..0 ignored, read zero
// - status 15 shows input present
// - charger-ok implies input present, faults drop
// - status 14 shows optimizer complete
// - status 13 assist active, processor hot never blocks
// - exits by command or fault, set flag
// - pin high and bit clear enables assist
// - entry disables loops, adjusts monitors
// - exit re-enables loops and limit pin
// - status 12 voltage regulation active
// - status 11 input current regulation active
// - status 10 fast charge active
// - status 9 precharge, 8 reverse power
module cvs_regs
  import cvs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input cvs_acc_type acc_in,
  input cvs_cond_type cond_in,
  input cvs_fault_type fault_in,
  input wire logic multi_function_control_pin_in,
  input wire logic assist_disable_bit_in,
  input wire logic adapter_ok_cfg_in,
  input wire logic system_voltage_cfg_in,
  input wire logic assist_exit_clear_in,
  output logic [15:0] rdata_out,
  output logic invalid_write_out,
  output logic [15:0] setpoint_mv_out,
  output logic charger_ok_indicator_out,
  output logic assist_exit_flag_out,
  output logic processor_hot_alert_n_out,
  output cvs_loop_type loops_out
);

  logic [15:0] cv_r;
  logic [15:0] cv_nxt;
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic invalid_r;
  logic invalid_nxt;
  logic any_fault;
  logic assist_active;
  logic exit_pulse;

  // ****************************************
  // charge-voltage setpoint
  // ****************************************
  always_comb
  begin
    cv_nxt = cv_r;
    invalid_nxt = 1'b0;
    if (acc_in.wr && acc_in.addr == CVS_OFS_CHARGE_VOLTAGE)
    begin
      if (acc_in.wdata[CVS_CV_RSVD_TOP_BIT])
      begin
        invalid_nxt = 1'b1;
      end
      else
      begin
        cv_nxt = acc_in.wdata & CVS_CV_SETPOINT_MASK;
      end
    end
  end

  // lsb is 8 mV, so the sum of weights is the field shifted up by three
  assign setpoint_mv_out = {1'b0, cv_r[CVS_CV_SET_MSB:CVS_CV_SET_LSB], 3'b000};

  // ****************************************
  // status flags
  // ****************************************
  assign any_fault = |fault_in;
  // charger-ok never stronger than input present
  assign charger_ok_indicator_out = cond_in.input_present & ~any_fault;

  always_comb
  begin
    status_nxt = 16'h0000;
    status_nxt[CVS_ST_INPUT_PRESENT] = cond_in.input_present;
    status_nxt[CVS_ST_OPTIMIZER_DONE] = cond_in.input_optimizer_done;
    status_nxt[CVS_ST_ASSIST_ACTIVE] = assist_active;
    status_nxt[CVS_ST_VOLT_REG] = cond_in.input_voltage_regulating;
    status_nxt[CVS_ST_CURR_REG] = cond_in.input_current_regulating;
    status_nxt[CVS_ST_FAST_CHARGE] = cond_in.fast_charge_active;
    status_nxt[CVS_ST_PRECHARGE] = cond_in.precharge_active;
    status_nxt[CVS_ST_REVERSE] = cond_in.reverse_power_active;
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (acc_in.rd)
    begin
      unique case (acc_in.addr)
        CVS_OFS_CHARGE_VOLTAGE: rdata_nxt = cv_r & CVS_CV_SETPOINT_MASK;
        CVS_OFS_STATE_FLAGS: rdata_nxt = status_r;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cv_r <= CVS_RST_CHARGE_VOLTAGE;
      status_r <= CVS_RST_STATE_FLAGS;
      rdata_r <= 16'h0000;
      invalid_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      cv_r <= cv_nxt;
      status_r <= status_nxt;
      rdata_r <= rdata_nxt;
      invalid_r <= invalid_nxt;
    end
  end

  assign rdata_out = rdata_r;
  assign invalid_write_out = invalid_r;

  // ****************************************
  // peak-assist mode
  // ****************************************
  cvs_assist_ctl u_assist
  (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .ctrl_pin_in(multi_function_control_pin_in),
    .assist_disable_bit_in(assist_disable_bit_in),
    .any_fault_in(any_fault),
    .adapter_ok_cfg_in(adapter_ok_cfg_in),
    .system_voltage_cfg_in(system_voltage_cfg_in),
    .assist_active_out(assist_active),
    .exit_pulse_out(exit_pulse),
    .loops_out(loops_out)
  );

  cvs_exit_flag u_exit
  (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .set_in(exit_pulse),
    .clear_in(assist_exit_clear_in),
    .flag_out(assist_exit_flag_out),
    .processor_hot_alert_n_out(processor_hot_alert_n_out)
  );

endmodule

// ===== verif/cvs_regs_sva.sv
// port assertions for the charge-voltage and status bank
`timescale 1ns/100ps
module cvs_regs_sva
  import cvs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input cvs_acc_type acc_in,
  input cvs_cond_type cond_in,
  input cvs_fault_type fault_in,
  input wire logic multi_function_control_pin_in,
  input wire logic assist_disable_bit_in,
  input wire logic [15:0] rdata_out,
  input wire logic invalid_write_out,
  input wire logic [15:0] setpoint_mv_out,
  input wire logic charger_ok_indicator_out,
  input wire logic assist_exit_flag_out,
  input wire logic processor_hot_alert_n_out,
  input cvs_loop_type loops_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic cv_wr;
  logic ivl;
  assign cv_wr = clk_en_in && acc_in.wr && acc_in.addr == CVS_OFS_CHARGE_VOLTAGE;
  // assist state seen through the voltage loop enable, low only in assist
  assign ivl = loops_out.input_voltage_loop_en;
  ok_needs_input_a: assert property (charger_ok_indicator_out |-> cond_in.input_present)
    else $error("charger ok without input");
  fault_drops_ok_a: assert property (|fault_in |-> !charger_ok_indicator_out)
    else $error("charger ok during fault");
  bad_write_flag_a: assert property (cv_wr && acc_in.wdata[15] |=> invalid_write_out)
    else $error("invalid write not flagged");
  setpoint_weight_a: assert property (cv_wr && !acc_in.wdata[15] |=>
    setpoint_mv_out == ($past(acc_in.wdata) & CVS_CV_SETPOINT_MASK)) else $error("setpoint wrong");
  status_input_a: assert property (clk_en_in && acc_in.rd && acc_in.addr == CVS_OFS_STATE_FLAGS &&
    $past(rst_n_in) |=> rdata_out[15] == $past(cond_in.input_present, 2)) else $error("input bit wrong");
  entry_cause_a: assert property ($fell(ivl) |->
    $past(multi_function_control_pin_in && !assist_disable_bit_in && fault_in == '0)) else $error("bad entry");
  entry_loops_a: assert property ($fell(ivl) |-> loops_out == 6'h01)
    else $error("entry loops wrong");
  exit_loops_a: assert property ($rose(ivl) |-> loops_out[5:2] == 4'hf ##1 assist_exit_flag_out)
    else $error("exit loops or flag wrong");
  fault_exit_a: assert property (clk_en_in && !ivl && fault_in != '0 |=> ivl)
    else $error("no exit on fault");
  alert_low_a: assert property (assist_exit_flag_out |-> !processor_hot_alert_n_out)
    else $error("alert not low");
  cover property (cv_wr);
  cover property ($fell(ivl));
  cover property (invalid_write_out);
endmodule

// ===== verif/cvs_host_model.sv
// host controller model issuing register strobes
`timescale 1ns/100ps
module cvs_host_model
  import cvs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic [15:0] rdata_in,
  output cvs_acc_type acc_out
);
  initial acc_out = '0;
  // one strobe cycle per access; released bus shows the inverse so stale data never matches
  task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge sys_clk_in);
    acc_out <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge sys_clk_in);
    acc_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    #1 q = rdata_in;
  endtask
endmodule

// ===== verif/cvs_regs_bench.sv
// self-checking bench for the charge-voltage and status bank
`timescale 1ns/100ps
module cvs_regs_bench
  import cvs_pkg::*;
;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic clk_en_in = 1'b1;
  cvs_acc_type acc;
  cvs_cond_type cond = '0;
  cvs_fault_type fault = '0;
  logic pin = 1'b0;
  logic dis = 1'b0;
  logic clr = 1'b0;
  logic [15:0] rdata;
  logic inv;
  logic [15:0] mv;
  logic ok;
  logic flag;
  logic alert_n;
  cvs_loop_type loops;
  logic [15:0] q;
  int mismatches = 0;
  int checked = 0;
  cvs_regs i_dut (.sys_clk_in, .rst_n_in, .clk_en_in, .acc_in(acc), .cond_in(cond), .fault_in(fault),
    .multi_function_control_pin_in(pin), .assist_disable_bit_in(dis), .adapter_ok_cfg_in(1'b1),
    .system_voltage_cfg_in(1'b0), .assist_exit_clear_in(clr), .rdata_out(rdata), .invalid_write_out(inv),
    .setpoint_mv_out(mv), .charger_ok_indicator_out(ok), .assist_exit_flag_out(flag),
    .processor_hot_alert_n_out(alert_n), .loops_out(loops));
  cvs_host_model host (.sys_clk_in, .rdata_in(rdata), .acc_out(acc));
  initial forever #2.5 sys_clk_in = ~sys_clk_in;
  task automatic go(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic t_regs;
    host.access(1'b0, CVS_OFS_CHARGE_VOLTAGE, 16'h0000, q);
    check("cv reset", q, CVS_RST_CHARGE_VOLTAGE);
    check("loops reset", 16'(loops), 16'h003e);
    host.access(1'b1, CVS_OFS_CHARGE_VOLTAGE, 16'h7fff, q);
    check("mv max", mv, 16'h7ff8);
    host.access(1'b0, CVS_OFS_CHARGE_VOLTAGE, 16'h0000, q);
    check("cv low bits", q, 16'h7ff8);
    host.access(1'b1, CVS_OFS_CHARGE_VOLTAGE, 16'hffff, q);
    check("invalid", 16'(inv), 16'h0001);
    host.access(1'b1, CVS_OFS_STATE_FLAGS, 16'hffff, q);
    host.access(1'b0, CVS_OFS_CHARGE_VOLTAGE, 16'h0000, q);
    check("cv kept", q, 16'h7ff8);
    host.access(1'b0, CVS_OFS_STATE_FLAGS, 16'h0000, q);
    check("status reset", q, CVS_RST_STATE_FLAGS);
    host.access(1'b1, CVS_OFS_CHARGE_VOLTAGE, 16'h1068, q);
    check("mv", mv, 16'h1068);
    host.access(1'b0, CVS_OFS_CHARGE_VOLTAGE, 16'h0000, q);
    check("cv readback", q, 16'h1068);
    host.access(1'b0, 8'h00, 16'h0000, q);
    check("unmapped", q, 16'h0000);
  endtask
  task automatic t_freeze;
    go(1);
    clk_en_in <= 1'b0;
    host.access(1'b1, CVS_OFS_CHARGE_VOLTAGE, 16'h0ab8, q);
    check("frozen mv", mv, 16'h1068);
    go(1);
    clk_en_in <= 1'b1;
    host.access(1'b0, CVS_OFS_CHARGE_VOLTAGE, 16'h0000, q);
    check("frozen cv", q, 16'h1068);
  endtask
  task automatic t_status;
    for (int i = 0; i < 7; i++)
    begin
      go(1);
      cond <= cvs_cond_type'(7'h01 << i);
      go(2);
      host.access(1'b0, CVS_OFS_STATE_FLAGS, 16'h0000, q);
      check("status", q, {cond[6:5], 1'b0, cond[4:0], 8'h00});
    end
    check("ok", 16'(ok), 16'h0001);
  endtask
  task automatic t_assist;
    go(1);
    pin <= 1'b1;
    go(2);
    #1 check("entry loops", 16'(loops), 16'h0001);
    host.access(1'b0, CVS_OFS_STATE_FLAGS, 16'h0000, q);
    check("assist bit", q, 16'ha000);
    go(1);
    pin <= 1'b0;
    go(3);
    #1 check("exit loops", 16'(loops), 16'h003e);
    check("exit flag", 16'({flag, alert_n}), 16'h0002);
    go(1);
    pin <= 1'b1;
    go(2);
    #1 check("entry under alert", 16'(loops), 16'h0001);
    go(1);
    fault <= 5'h10;
    go(3);
    #1 check("fault exit", 16'(loops), 16'h003e);
    check("ok fault", 16'(ok), 16'h0000);
    go(1);
    fault <= '0;
    pin <= 1'b0;
    clr <= 1'b1;
    go(1);
    clr <= 1'b0;
    go(2);
    #1 check("cleared", 16'({flag, alert_n}), 16'h0001);
    go(1);
    dis <= 1'b1;
    pin <= 1'b1;
    go(3);
    #1 check("disabled", 16'(loops), 16'h003e);
    go(1);
    dis <= 1'b0;
    go(3);
    #1 check("enabled", 16'(loops), 16'h0001);
  endtask
  task automatic t_reset;
    go(1);
    pin <= 1'b0;
    go(3);
    rst_n_in <= 1'b0;
    go(2);
    check("reset loops", 16'(loops), 16'h003c);
    check("reset flag", 16'({flag, alert_n}), 16'h0001);
    go(1);
    rst_n_in <= 1'b1;
    host.access(1'b0, CVS_OFS_CHARGE_VOLTAGE, 16'h0000, q);
    check("reset cv", q, CVS_RST_CHARGE_VOLTAGE);
  endtask
  initial
  begin
    go(5);
    rst_n_in <= 1'b1;
    t_regs();
    t_freeze();
    t_status();
    t_assist();
    t_reset();
    finish_test();
  end
  // hang guard well above the whole sequence
  initial
  begin
    go(20000);
    mismatches++;
    finish_test();
  end
endmodule
bind cvs_regs cvs_regs_sva i_sva (.sys_clk_in, .rst_n_in, .clk_en_in, .acc_in, .cond_in, .fault_in,
  .multi_function_control_pin_in, .assist_disable_bit_in, .rdata_out, .invalid_write_out,
  .setpoint_mv_out, .charger_ok_indicator_out, .assist_exit_flag_out, .processor_hot_alert_n_out, .loops_out);
